// File: pkg/state_store_defines.svh
// constants for the state storage protection block
// assumes inclusion by bare name from package and design files
`ifndef STATE_STORE_DEFINES_SVH
`define STATE_STORE_DEFINES_SVH

// ---------------------------------------------------------------
// command opcodes
// ---------------------------------------------------------------
`define SS_OP_SELECT     3'h0
`define SS_OP_SELECT_Q   3'h1
`define SS_OP_PROTECT    3'h2
`define SS_OP_PROTECT_Q  3'h3
`define SS_OP_ERASE      3'h4
`define SS_OP_SAVE       3'h5

// ---------------------------------------------------------------
// error codes
// ---------------------------------------------------------------
`define SS_ERR_NONE      2'h0
`define SS_ERR_PROTECTED 2'h1
`define SS_ERR_RANGE     2'h2

// ---------------------------------------------------------------
// slot numbering and reset values
// ---------------------------------------------------------------
`define SS_SLOT_W        4
`define SS_SLOT_MIN      4'h1
`define SS_SLOT_MAX      4'h9
`define SS_SLOT_NONE     4'h0
`define SS_NUM_SLOTS     9
`define SS_FLAG_RESET    1'h0

`endif

// File: pkg/state_store_pkg.sv
// types for the state storage protection block
// assumes the defines header is on the include path
`include "state_store_defines.svh"

package state_store_pkg;

  // command kinds
  typedef enum logic [2:0] {
    OP_SELECT    = `SS_OP_SELECT,
    OP_SELECT_Q  = `SS_OP_SELECT_Q,
    OP_PROTECT   = `SS_OP_PROTECT,
    OP_PROTECT_Q = `SS_OP_PROTECT_Q,
    OP_ERASE     = `SS_OP_ERASE,
    OP_SAVE      = `SS_OP_SAVE
  } cmd_op_t;

  // error kinds
  typedef enum logic [1:0] {
    ERR_NONE      = `SS_ERR_NONE,
    ERR_PROTECTED = `SS_ERR_PROTECTED,
    ERR_RANGE     = `SS_ERR_RANGE
  } err_code_t;

  typedef logic [`SS_SLOT_W-1:0] slot_t;

endpackage : state_store_pkg

// File: pkg/slot_flag_if.sv
// carrier between the command logic and the protection flag table
// assumes both ends run on the same clock
`include "state_store_defines.svh"

interface slot_flag_if;
  logic wr_en;
  state_store_pkg::slot_t wr_slot;
  logic wr_val;
  state_store_pkg::slot_t rd_slot;
  logic rd_val;

  modport ctrl (output wr_en, output wr_slot, output wr_val, output rd_slot, input rd_val);
  modport table_side (input wr_en, input wr_slot, input wr_val, input rd_slot, output rd_val);
endinterface : slot_flag_if

// File: logic/slot_protect_table.sv
// protection flag storage, one flag per user slot
// assumes the controller only writes slots in range
`include "state_store_defines.svh"

module slot_protect_table #(
  parameter int NUM_SLOTS = `SS_NUM_SLOTS
) (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  slot_flag_if.table_side flag_bus
);

  logic [NUM_SLOTS:1] flag_r;
  logic [NUM_SLOTS:1] flag_nxt;

  // ---------------------------------------------------------------
  // flag storage
  // ---------------------------------------------------------------
  genvar i;
  generate
    for (i = 1; i <= NUM_SLOTS; i++) begin : g_flag
      // next value per slot, written by index
      assign flag_nxt[i] = (flag_bus.wr_en && flag_bus.wr_slot == `SS_SLOT_W'(i)) ?
        flag_bus.wr_val : flag_r[i];
    end
  endgenerate

  // one register for the whole table, so every bit has a single driver
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      flag_r <= {NUM_SLOTS{`SS_FLAG_RESET}};
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // read by index; slot 0 reads as set, above the table as clear
  always_comb begin
    flag_bus.rd_val = 1'h0;
    if (flag_bus.rd_slot == `SS_SLOT_NONE) begin
      flag_bus.rd_val = 1'h1;
    end else if (int'(flag_bus.rd_slot) <= NUM_SLOTS) begin
      flag_bus.rd_val = flag_r[flag_bus.rd_slot];
    end
  end

endmodule // slot_protect_table

// File: logic/state_store_protection.sv
// command handling for user state slots and their write protection
// assumes commands arrive one per cycle, synchronous to sys_clk_in
//
// Contract
// - erase of unprotected slot 1..9 pulses the erase strobe for that slot
// - erase of protected slot leaves it alone and reports slot-protected
// - erase naming slot 0 leaves it alone and reports out-of-range
// - select takes slot 1..9 and keeps it as the current slot
// - slot 0 always protected; selecting it reports out-of-range, slot kept
// - select query returns the current slot number
// - protect on/off sets or clears the flag of the current slot
// - save to a protected slot is not granted and reports slot-protected
// - protection commands on slot 0 report out-of-range
// - protect query returns the flag of the current slot
`include "state_store_defines.svh"

module state_store_protection #(
  parameter int NUM_SLOTS = `SS_NUM_SLOTS
) (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic cmd_valid_in,
  input wire logic [2:0] cmd_op_in,
  input wire logic [`SS_SLOT_W-1:0] cmd_slot_in,
  input wire logic cmd_arg_in,
  output logic rsp_valid_out,
  output logic [`SS_SLOT_W-1:0] rsp_data_out,
  output logic err_valid_out,
  output logic [1:0] err_code_out,
  output logic erase_out,
  output logic save_out,
  output logic [`SS_SLOT_W-1:0] slot_out
);

  // ---------------------------------------------------------------
  // decoding helpers
  // ---------------------------------------------------------------
  function automatic logic in_range(input logic [`SS_SLOT_W-1:0] s);
    in_range = (s >= `SS_SLOT_MIN) && (s <= `SS_SLOT_MAX);
  endfunction

  state_store_pkg::slot_t sel_r;
  state_store_pkg::cmd_op_t op;
  logic cmd_ok;
  logic tgt_hit;

  slot_flag_if flag_bus ();

  slot_protect_table #(
    .NUM_SLOTS(NUM_SLOTS)
  ) u_table (
    .sys_clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .flag_bus(flag_bus)
  );

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  // illegal opcodes fall out as no command
  always_comb begin
    op = state_store_pkg::cmd_op_t'(cmd_op_in);
    cmd_ok = cmd_valid_in;
    unique case (cmd_op_in)
      `SS_OP_SELECT, `SS_OP_SELECT_Q, `SS_OP_PROTECT,
      `SS_OP_PROTECT_Q, `SS_OP_ERASE, `SS_OP_SAVE: cmd_ok = cmd_valid_in;
      default: cmd_ok = 1'h0;
    endcase
  end

  // flag port: protect commands act on the current slot, others on the named one
  always_comb begin
    flag_bus.rd_slot = cmd_slot_in;
    if (op == state_store_pkg::OP_PROTECT_Q || op == state_store_pkg::OP_PROTECT) begin
      flag_bus.rd_slot = sel_r;
    end
    flag_bus.wr_en = cmd_ok && op == state_store_pkg::OP_PROTECT && in_range(sel_r);
    flag_bus.wr_slot = sel_r;
    flag_bus.wr_val = cmd_arg_in;
  end
  assign tgt_hit = flag_bus.rd_val;

  // ---------------------------------------------------------------
  // current slot
  // ---------------------------------------------------------------
  // slot 0 and above 9 never replace the held slot
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sel_r <= `SS_SLOT_NONE;
    end else if (cmd_ok && op == state_store_pkg::OP_SELECT && in_range(cmd_slot_in)) begin
      sel_r <= cmd_slot_in;
    end
  end

  // ---------------------------------------------------------------
  // query answers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rsp_valid_out <= 1'h0;
      rsp_data_out <= `SS_SLOT_NONE;
    end else begin
      rsp_valid_out <= 1'h0;
      if (cmd_ok && op == state_store_pkg::OP_SELECT_Q) begin
        rsp_valid_out <= 1'h1;
        rsp_data_out <= sel_r;
      end else if (cmd_ok && op == state_store_pkg::OP_PROTECT_Q && in_range(sel_r)) begin
        rsp_valid_out <= 1'h1;
        rsp_data_out <= {{(`SS_SLOT_W-1){1'h0}}, tgt_hit};
      end
    end
  end

  // ---------------------------------------------------------------
  // erase and save strobes
  // ---------------------------------------------------------------
  // strobe only when the target is in range and unprotected
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      erase_out <= 1'h0;
      save_out <= 1'h0;
      slot_out <= `SS_SLOT_NONE;
    end else begin
      erase_out <= 1'h0;
      save_out <= 1'h0;
      if (cmd_ok && in_range(cmd_slot_in) && !tgt_hit) begin
        if (op == state_store_pkg::OP_ERASE) begin
          erase_out <= 1'h1;
          slot_out <= cmd_slot_in;
        end else if (op == state_store_pkg::OP_SAVE) begin
          save_out <= 1'h1;
          slot_out <= cmd_slot_in;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // error reporting
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      err_valid_out <= 1'h0;
      err_code_out <= `SS_ERR_NONE;
    end else begin
      err_valid_out <= 1'h0;
      err_code_out <= `SS_ERR_NONE;
      if (cmd_ok) begin
        unique case (op)
          state_store_pkg::OP_SELECT: begin
            if (!in_range(cmd_slot_in)) begin
              err_valid_out <= 1'h1;
              err_code_out <= `SS_ERR_RANGE;
            end
          end
          state_store_pkg::OP_PROTECT, state_store_pkg::OP_PROTECT_Q: begin
            if (!in_range(sel_r)) begin
              err_valid_out <= 1'h1;
              err_code_out <= `SS_ERR_RANGE;
            end
          end
          state_store_pkg::OP_ERASE, state_store_pkg::OP_SAVE: begin
            if (!in_range(cmd_slot_in)) begin
              err_valid_out <= 1'h1;
              err_code_out <= `SS_ERR_RANGE;
            end else if (tgt_hit) begin
              err_valid_out <= 1'h1;
              err_code_out <= `SS_ERR_PROTECTED;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_erase_free;
    cmd_ok && op == state_store_pkg::OP_ERASE && in_range(cmd_slot_in) && !tgt_hit;
  endsequence

  sequence s_prot_write;
    cmd_ok && op == state_store_pkg::OP_PROTECT && in_range(sel_r);
  endsequence

  sequence s_prot_read;
    cmd_ok && op == state_store_pkg::OP_PROTECT_Q && in_range(sel_r);
  endsequence

  property p_erase_free;
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    s_erase_free |=> erase_out && slot_out == $past(cmd_slot_in) && !err_valid_out;
  endproperty
  a_erase_free: assert property (p_erase_free) else $error("free erase not strobed");

  property p_erase_prot;
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    (cmd_ok && op == state_store_pkg::OP_ERASE && in_range(cmd_slot_in) && tgt_hit)
      |=> !erase_out && err_valid_out && err_code_out == `SS_ERR_PROTECTED;
  endproperty
  a_erase_prot: assert property (p_erase_prot) else $error("protected erase not refused");

  property p_erase_zero;
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    (cmd_ok && op == state_store_pkg::OP_ERASE && cmd_slot_in == `SS_SLOT_NONE)
      |=> !erase_out && err_valid_out && err_code_out == `SS_ERR_RANGE;
  endproperty
  a_erase_zero: assert property (p_erase_zero) else $error("slot 0 erase not refused");

  property p_select;
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    (cmd_ok && op == state_store_pkg::OP_SELECT && in_range(cmd_slot_in))
      ##1 (cmd_ok && op == state_store_pkg::OP_SELECT_Q)
      |=> rsp_valid_out && rsp_data_out == $past(cmd_slot_in, 2);
  endproperty
  a_select: assert property (p_select) else $error("selected slot not reported");

  property p_select_zero;
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    (cmd_ok && op == state_store_pkg::OP_SELECT && !in_range(cmd_slot_in))
      |=> $stable(sel_r) && err_valid_out && err_code_out == `SS_ERR_RANGE;
  endproperty
  a_select_zero: assert property (p_select_zero) else $error("bad select not refused");

  property p_protect;
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    s_prot_write ##1 s_prot_read |=> rsp_valid_out && rsp_data_out[0] == $past(cmd_arg_in, 2);
  endproperty
  a_protect: assert property (p_protect) else $error("protect flag not stored");

  property p_save_prot;
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    (cmd_ok && op == state_store_pkg::OP_SAVE && in_range(cmd_slot_in) && tgt_hit)
      |=> !save_out && err_valid_out && err_code_out == `SS_ERR_PROTECTED;
  endproperty
  a_save_prot: assert property (p_save_prot) else $error("protected save granted");

  property p_prot_zero;
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    (cmd_ok && (op == state_store_pkg::OP_PROTECT || op == state_store_pkg::OP_PROTECT_Q)
      && sel_r == `SS_SLOT_NONE) |=> err_valid_out && err_code_out == `SS_ERR_RANGE
      && !rsp_valid_out;
  endproperty
  a_prot_zero: assert property (p_prot_zero) else $error("slot 0 protect not refused");

  property p_err_code;
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    err_valid_out |-> err_code_out != `SS_ERR_NONE && $past(cmd_valid_in);
  endproperty
  a_err_code: assert property (p_err_code) else $error("error pulse without cause");

endmodule // state_store_protection

// File: testbench/remote_ctrl_model.sv
// controller model driving the command inputs of the protection block
// assumes the caller enters a task just after a rising edge of sys_clk_in
`include "state_store_defines.svh"

module remote_ctrl_model (
  input wire logic sys_clk_in,
  output logic cmd_valid_out,
  output logic [2:0] cmd_op_out,
  output logic [`SS_SLOT_W-1:0] cmd_slot_out,
  output logic cmd_arg_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // -------------------------------------------------------------
  // command issue
  // -------------------------------------------------------------
  logic had_select;

  // idle lines at time zero
  initial begin
    cmd_valid_out = 1'b0;
    cmd_op_out = 3'h7;
    cmd_slot_out = 4'h0;
    cmd_arg_out = 1'b0;
    had_select = 1'b0;
  end

  // one command, held until the taking edge; returns just after it; a select query before any select is not driven and returns at once
  task automatic send(input logic [2:0] op, input logic [3:0] slot, input logic arg);
    if (op == 3'(state_store_pkg::OP_SELECT_Q) && !had_select) begin
      $display("controller model: select query held back, no slot chosen yet");
    end else begin
      if (op == 3'(state_store_pkg::OP_SELECT)) had_select = 1'b1;
      cmd_valid_out = 1'b1;
      cmd_op_out = op;
      cmd_slot_out = slot;
      cmd_arg_out = arg;
      @(posedge sys_clk_in);
      #1;
    end
  endtask

  // valid drops and the opcode holds; slot and argument lines show the inverse of their last value
  task automatic idle();
    cmd_valid_out = 1'b0;
    cmd_slot_out = ~cmd_slot_out;
    cmd_arg_out = ~cmd_arg_out;
    @(posedge sys_clk_in);
    #1;
  endtask
endmodule // remote_ctrl_model

// File: testbench/state_store_protection_test.sv
// self-checking bench for the slot protection command block
// assumes the controller model and the design files are compiled first
module state_store_protection_test;
  timeunit 1ns;
  timeprecision 100ps;

  // -------------------------------------------------------------
  // harness
  // -------------------------------------------------------------
  logic sys_clk_in;
  logic arst_n_in;
  logic cmd_valid;
  logic [2:0] cmd_op;
  logic [3:0] cmd_slot;
  logic cmd_arg;
  logic rsp_valid_out;
  logic [3:0] rsp_data_out;
  logic err_valid_out;
  logic [1:0] err_code_out;
  logic erase_out;
  logic save_out;
  logic [3:0] slot_out;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;

  // free running clock
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  remote_ctrl_model ctrl (.sys_clk_in(sys_clk_in), .cmd_valid_out(cmd_valid),
    .cmd_op_out(cmd_op), .cmd_slot_out(cmd_slot), .cmd_arg_out(cmd_arg));

  state_store_protection #(.NUM_SLOTS(9)) dut (.sys_clk_in(sys_clk_in),
    .arst_n_in(arst_n_in), .cmd_valid_in(cmd_valid), .cmd_op_in(cmd_op),
    .cmd_slot_in(cmd_slot), .cmd_arg_in(cmd_arg), .rsp_valid_out(rsp_valid_out),
    .rsp_data_out(rsp_data_out), .err_valid_out(err_valid_out),
    .err_code_out(err_code_out), .erase_out(erase_out), .save_out(save_out),
    .slot_out(slot_out));

  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("counts: checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  // protection commands with no slot chosen yet
  task automatic t_no_slot();
    ctrl.send(3'h3, 4'h5, 1'b0);
    chk({rsp_valid_out, err_valid_out, err_code_out}, 4'h6);
    ctrl.send(3'h2, 4'h5, 1'b1);
    chk({rsp_valid_out, err_valid_out, err_code_out}, 4'h6);
    $display("test no_slot done");
  endtask

  // every slot selected and read back, then the refused slots
  task automatic t_select();
    for (int s = 1; s <= 9; s++) begin
      ctrl.send(3'h0, 4'(s), 1'b0);
      chk({rsp_valid_out, err_valid_out}, 2'h0);
      ctrl.send(3'h1, 4'h0, 1'b0);
      chk({rsp_valid_out, rsp_data_out}, {1'b1, 4'(s)});
    end
    ctrl.send(3'h0, 4'h0, 1'b0);
    chk({err_valid_out, err_code_out}, 3'h6);
    ctrl.send(3'h0, 4'ha, 1'b0);
    chk({err_valid_out, err_code_out}, 3'h6);
    ctrl.send(3'h1, 4'h0, 1'b0);
    chk({rsp_valid_out, rsp_data_out}, 5'h19);
    $display("test select done");
  endtask

  // odd slots protected, even left open, each read back
  task automatic t_protect();
    for (int s = 1; s <= 9; s++) begin
      ctrl.send(3'h0, 4'(s), 1'b0);
      ctrl.send(3'h2, 4'h0, s[0]);
      chk({err_valid_out, rsp_valid_out}, 2'h0);
      ctrl.send(3'h3, 4'h0, 1'b0);
      chk({rsp_valid_out, rsp_data_out}, {1'b1, 3'h0, s[0]});
    end
    $display("test protect done");
  endtask

  // erase and save on every slot number, slot 0 included
  task automatic t_erase_save();
    logic [1:0] e;
    logic [3:0] last;
    last = 4'h0;
    for (int s = 0; s <= 9; s++) begin
      e = (s == 0) ? 2'h2 : (s[0] ? 2'h1 : 2'h0);
      ctrl.send(3'h4, 4'(s), 1'b0);
      if (e == 2'h0) last = 4'(s);
      chk({err_valid_out, err_code_out, erase_out, save_out}, {e != 2'h0, e, e == 2'h0, 1'b0});
      chk(slot_out, last);
      ctrl.send(3'h5, 4'(s), 1'b0);
      chk({err_valid_out, err_code_out, erase_out, save_out}, {e != 2'h0, e, 1'b0, e == 2'h0});
      chk(slot_out, last);
    end
    $display("test erase_save done");
  endtask

  // unprotect then erase at once, then the unused opcodes
  task automatic t_unprotect();
    ctrl.send(3'h0, 4'h3, 1'b0);
    ctrl.send(3'h2, 4'h0, 1'b0);
    ctrl.send(3'h4, 4'h3, 1'b0);
    chk({err_valid_out, erase_out, slot_out}, 6'h13);
    ctrl.send(3'h6, 4'h3, 1'b1);
    chk({rsp_valid_out, err_valid_out, erase_out, save_out}, 4'h0);
    ctrl.send(3'h7, 4'h3, 1'b1);
    chk({rsp_valid_out, err_valid_out, erase_out, save_out}, 4'h0);
    ctrl.idle();
    chk({rsp_valid_out, err_valid_out, err_code_out, erase_out}, 5'h0);
    $display("test unprotect done");
  endtask

  // -------------------------------------------------------------
  // sequence and hang guard
  // -------------------------------------------------------------
  initial begin
    arst_n_in = 1'b0;
    repeat (10) @(posedge sys_clk_in);
    #1;
    arst_n_in = 1'b1;
    @(posedge sys_clk_in);
    #1;
    t_no_slot();
    t_select();
    t_protect();
    t_erase_save();
    t_unprotect();
    conclude();
  end

  // cycle ceiling far above the 87 cycles the tests need
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      conclude();
    end
  end
endmodule // state_store_protection_test
